/* File: rtl/rrs_responder.sv */
// Response framer for operations-record and breaker/I-O status messages, APB programmed
`include "rrs_map.svh"

module rrs_responder
  import rrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] contact_in_hi,
  input wire logic breaker_aux_a_contact,
  input wire logic breaker_aux_b_contact,
  input wire logic selector_aux_contact,
  input wire logic [4:0] contact_in_lo,
  input wire logic [7:0] self_test_hi,
  input wire logic [3:0] self_test_lo,
  input wire logic [1:0] output_hi,
  input wire logic trip_output,
  input wire logic close_output,
  input wire logic [5:0] output_lo,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  rrs_state_s r;
  rrs_state_s next_r;

  logic addr_ok;
  logic setup;
  logic wr_access;
  logic start_req;
  logic start_reserved;
  logic start_exists;
  rrs_kind_e start_kind;
  rrs_frame_t built;

  always_comb begin
    case (paddr)
      `RRS_OFF_CTRL, `RRS_OFF_DATE, `RRS_OFF_TIME, `RRS_OFF_EVENT,
      `RRS_OFF_OPNUM, `RRS_OFF_STATUS, `RRS_OFF_RELAY: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && addr_ok;
  assign start_req = wr_access && (paddr == `RRS_OFF_CTRL) && pstrb[0] &&
                     pwdata[`RRS_CTRL_START_BIT];
  assign start_kind = rrs_kind_e'(pwdata[`RRS_CTRL_KIND_MSB:`RRS_CTRL_KIND_LSB]);

  // Exists flag written with the start counts for this very response
  assign start_exists = pstrb[1] ? pwdata[`RRS_CTRL_EXISTS_BIT] : r.exists;

  // A logged event never carries a reserved code
  assign start_reserved = (start_kind != RRS_KIND_BREAKER) && start_exists &&
                          (r.event_num >= `RRS_RESERVED_LO) &&
                          (r.event_num <= `RRS_RESERVED_HI);

  // Whole response assembled at once, so later pin changes cannot tear it
  always_comb begin
    built = '0;
    built[0] = r.relay_status;
    if (start_kind == RRS_KIND_BREAKER) begin
      built[1] = `RRS_CODE_BREAKER;
      built[2] = `RRS_MSGS_BREAKER;
      built[3] = contact_in_hi;
      built[4] = {contact_in_lo, selector_aux_contact, breaker_aux_b_contact,
                  breaker_aux_a_contact};
      built[5] = self_test_hi;
      built[6] = {4'h0, self_test_lo};
      built[7] = {6'h00, output_hi};
      built[8] = {output_lo, close_output, trip_output};
    end else begin
      if (start_kind == RRS_KIND_NEXT_RECORD) begin
        built[1] = `RRS_CODE_NEXT_RECORD;
      end else begin
        built[1] = `RRS_CODE_OPS_RECORD;
      end
      built[2] = `RRS_MSGS_RECORD;
      if (start_exists) begin
        built[3] = r.date[23:16];
        built[4] = r.date[15:8];
        built[5] = r.date[7:0];
        built[6] = r.stamp[31:24];
        built[7] = r.stamp[23:16];
        built[8] = r.stamp[15:8];
        built[9] = r.stamp[7:0];
        built[10] = r.event_num;
        built[11] = r.event_val[15:8];
        built[12] = r.event_val[7:0];
        built[13] = r.opnum[15:8];
        built[14] = r.opnum[7:0];
      end
      // Missing entry leaves bytes 3 to 14 at zero
    end
  end

  always_comb begin
    next_r = r;

    // Registered read data, prepared in the setup phase
    if (setup) begin
      case (paddr)
        `RRS_OFF_CTRL: begin
          next_r.prdata = 32'h0000_0000;
          next_r.prdata[`RRS_CTRL_KIND_MSB:`RRS_CTRL_KIND_LSB] = r.kind;
          next_r.prdata[`RRS_CTRL_EXISTS_BIT] = r.exists;
        end
        `RRS_OFF_DATE: next_r.prdata = {8'h00, r.date};
        `RRS_OFF_TIME: next_r.prdata = r.stamp;
        `RRS_OFF_EVENT: next_r.prdata = {r.event_val, 8'h00, r.event_num};
        `RRS_OFF_OPNUM: next_r.prdata = {16'h0000, r.opnum};
        `RRS_OFF_STATUS: begin
          next_r.prdata = 32'h0000_0000;
          next_r.prdata[`RRS_STAT_BUSY_BIT] = (r.state == RRS_ST_SEND);
          next_r.prdata[`RRS_STAT_REFUSED_BIT] = r.refused;
          next_r.prdata[`RRS_STAT_IDX_MSB:`RRS_STAT_IDX_LSB] = r.idx;
        end
        `RRS_OFF_RELAY: next_r.prdata = {24'h00_0000, r.relay_status};
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end

    if (wr_access) begin
      case (paddr)
        `RRS_OFF_CTRL: begin
          if (pstrb[0]) begin
            next_r.kind = start_kind;
          end
          if (pstrb[1]) begin
            next_r.exists = pwdata[`RRS_CTRL_EXISTS_BIT];
          end
        end
        `RRS_OFF_DATE: begin
          for (int b = 0; b < 3; b++) begin
            if (pstrb[b]) begin
              next_r.date[b*8 +: 8] = pwdata[b*8 +: 8];
            end
          end
        end
        `RRS_OFF_TIME: begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              next_r.stamp[b*8 +: 8] = pwdata[b*8 +: 8];
            end
          end
        end
        `RRS_OFF_EVENT: begin
          if (pstrb[0]) begin
            next_r.event_num = pwdata[`RRS_EVENT_NUM_MSB:`RRS_EVENT_NUM_LSB];
          end
          if (pstrb[2]) begin
            next_r.event_val[7:0] = pwdata[23:16];
          end
          if (pstrb[3]) begin
            next_r.event_val[15:8] = pwdata[31:24];
          end
        end
        `RRS_OFF_OPNUM: begin
          if (pstrb[0]) begin
            next_r.opnum[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            next_r.opnum[15:8] = pwdata[15:8];
          end
        end
        `RRS_OFF_STATUS: begin
          if (pstrb[0] && pwdata[`RRS_STAT_REFUSED_BIT]) begin
            next_r.refused = 1'b0;
          end
        end
        `RRS_OFF_RELAY: begin
          if (pstrb[0]) begin
            next_r.relay_status = pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    case (r.state)
      RRS_ST_IDLE: begin
        if (start_req) begin
          if (start_reserved || (start_kind > RRS_KIND_BREAKER)) begin
            next_r.refused = 1'b1;
          end else begin
            next_r.frame = built;
            next_r.tx_data = built[0];
            next_r.idx = 4'h0;
            if (start_kind == RRS_KIND_BREAKER) begin
              next_r.last = `RRS_LAST_IDX_BREAKER;
            end else begin
              next_r.last = `RRS_LAST_IDX_RECORD;
            end
            next_r.state = RRS_ST_SEND;
          end
        end
      end
      RRS_ST_SEND: begin
        // Start while a response is going out is refused, flag set wins
        if (start_req) begin
          next_r.refused = 1'b1;
        end
        if (tx_ready) begin
          if (r.idx == r.last) begin
            next_r.state = RRS_ST_IDLE;
          end else begin
            next_r.idx = r.idx + 4'h1;
            next_r.tx_data = r.frame[r.idx + 4'h1];
          end
        end
      end
      default: next_r.state = RRS_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign tx_data = r.tx_data;
  assign tx_valid = (r.state == RRS_ST_SEND);

endmodule

/* File: rtl/rrs_map.svh */
// Register offsets, field positions, message codes and counts of the responder
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH

`define RRS_OFF_CTRL 8'h00
`define RRS_OFF_DATE 8'h04
`define RRS_OFF_TIME 8'h08
`define RRS_OFF_EVENT 8'h0c
`define RRS_OFF_OPNUM 8'h10
`define RRS_OFF_STATUS 8'h14
`define RRS_OFF_RELAY 8'h18

`define RRS_CTRL_KIND_LSB 0
`define RRS_CTRL_KIND_MSB 1
`define RRS_CTRL_START_BIT 4
`define RRS_CTRL_EXISTS_BIT 8

`define RRS_STAT_BUSY_BIT 0
`define RRS_STAT_REFUSED_BIT 1
`define RRS_STAT_IDX_LSB 8
`define RRS_STAT_IDX_MSB 11

`define RRS_EVENT_NUM_LSB 0
`define RRS_EVENT_NUM_MSB 7
`define RRS_EVENT_VAL_LSB 16
`define RRS_EVENT_VAL_MSB 31

`define RRS_CODE_OPS_RECORD 8'h5c
`define RRS_CODE_NEXT_RECORD 8'h5d
`define RRS_CODE_BREAKER 8'h5e
`define RRS_MSGS_RECORD 8'h05
`define RRS_MSGS_BREAKER 8'h03
`define RRS_LAST_IDX_RECORD 4'he
`define RRS_LAST_IDX_BREAKER 4'h8

`define RRS_RESERVED_LO 8'hc8
`define RRS_RESERVED_HI 8'hd6

`endif

/* File: rtl/rrs_pkg.sv */
// Types shared by the relay record and status responder
package rrs_pkg;

  typedef enum logic [1:0] {
    RRS_KIND_OPS_RECORD = 2'b00,
    RRS_KIND_NEXT_RECORD = 2'b01,
    RRS_KIND_BREAKER = 2'b10
  } rrs_kind_e;

  typedef enum logic [0:0] {
    RRS_ST_IDLE = 1'b0,
    RRS_ST_SEND = 1'b1
  } rrs_state_e;

  typedef logic [14:0][7:0] rrs_frame_t;

  typedef struct packed {
    rrs_state_e state;
    logic [3:0] idx;
    logic [3:0] last;
    rrs_frame_t frame;
    logic [7:0] tx_data;
    logic [31:0] prdata;
    rrs_kind_e kind;
    logic exists;
    logic [23:0] date;
    logic [31:0] stamp;
    logic [7:0] event_num;
    logic [15:0] event_val;
    logic [15:0] opnum;
    logic [7:0] relay_status;
    logic refused;
  } rrs_state_s;

endpackage

/* File: sim/rrs_properties.sv */
// Port checker of the responder
module rrs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] cnt;
  logic brk;
  wire acc = tx_valid && tx_ready;
  wire [3:0] last = brk ? 4'h8 : 4'he;
  // Byte index within the frame, and frame kind from its code byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      brk <= 1'b0;
    end else begin
      cnt <= !tx_valid ? 4'h0 : acc ? cnt + 4'h1 : cnt;
      if (tx_valid && cnt == 4'h1) brk <= tx_data == 8'h5e;
    end
  end
  sequence s_start;
    psel && penable && pwrite && paddr == 8'h00 && pstrb[0] && pwdata[4]
      && pwdata[1:0] == 2'b10 && !tx_valid;
  endsequence
  sequence s_hold;
    tx_valid && !tx_ready;
  endsequence
  a_start_valid: assert property (s_start |=> tx_valid && cnt == 4'h0)
    else $error("start gave no frame");
  a_data_hold: assert property (s_hold |=> tx_valid && $stable(tx_data))
    else $error("byte dropped while stalled");
  a_code_byte: assert property (tx_valid && cnt == 4'h1 |->
    tx_data inside {8'h5c, 8'h5d, 8'h5e})
    else $error("bad code byte");
  a_msg_count: assert property (tx_valid && cnt == 4'h2 |-> tx_data == (brk ? 8'h03 : 8'h05))
    else $error("bad message count");
  a_frame_end: assert property (acc && cnt == last |=> !tx_valid)
    else $error("frame too long");
  a_frame_cont: assert property (tx_valid && !(acc && cnt == last) |=> tx_valid)
    else $error("frame too short");
  a_selftest_pad: assert property (tx_valid && brk && cnt == 4'h6 |->
    tx_data[7:4] == 4'h0)
    else $error("self-test pad bits set");
  a_event_code: assert property (tx_valid && !brk && cnt == 4'ha |->
    !(tx_data inside {[8'hc8:8'hd6]}))
    else $error("reserved event sent");
endmodule

bind rrs_responder rrs_chk u_rrs_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .tx_data, .tx_valid, .tx_ready);

/* File: sim/rrs_host.sv */
// Host-side byte sink that can stall every other cycle
module rrs_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [16];
  int n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      n <= 0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got[n % 16] <= tx_data;
        n <= n + 1;
      end
    end
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench of the responder
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic ba, bb, sa, trp, cls, tx_valid, tx_ready, slow;
  logic [7:0] paddr, tx_data, c_hi, st_hi;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, st_lo;
  logic [4:0] c_lo;
  logic [1:0] o_hi;
  logic [5:0] o_lo;
  logic [7:0] ex [15];
  int err_total, n_checks;
  rrs_responder u_rrs_responder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .contact_in_hi(c_hi),
    .breaker_aux_a_contact(ba), .breaker_aux_b_contact(bb), .selector_aux_contact(sa),
    .contact_in_lo(c_lo), .self_test_hi(st_hi), .self_test_lo(st_lo), .output_hi(o_hi),
    .trip_output(trp), .close_output(cls), .output_lo(o_lo), .tx_data, .tx_valid, .tx_ready);
  rrs_host u_rrs_host (.pclk, .presetn, .tx_data, .tx_valid, .slow, .tx_ready);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic frame(input logic [1:0] kd, input logic xs, input int len);
    int b, k;
    b = u_rrs_host.n;
    apb(1'b1, 8'h00, {23'h0, xs, 3'h0, 1'b1, 2'h0, kd});
    // Pins move after start; the frame must keep the snapshot
    c_hi <= ~c_hi;
    st_hi <= ~st_hi;
    o_lo <= ~o_lo;
    k = 0;
    while (tx_valid === 1'b1 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(u_rrs_host.n - b), 32'(len));
    for (int i = 0; i < len; i++) chk(u_rrs_host.got[(b + i) % 16], ex[i]);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #200us;
    err_total++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, e} = '0;
    pstrb = 4'hf;
    {c_hi, ba, bb, sa, c_lo, st_hi, st_lo, o_hi, trp, cls, o_lo} = '0;
    slow = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h18, 32'ha5);
    apb(1'b1, 8'h04, 32'h170c1f);
    apb(1'b1, 8'h08, 32'h05123456);
    apb(1'b1, 8'h0c, 32'hbeef00ff);
    apb(1'b1, 8'h10, 32'h1234);
    ex = '{8'ha5, 8'h5c, 8'h05, 8'h17, 8'h0c, 8'h1f, 8'h05, 8'h12, 8'h34, 8'h56, 8'hff,
      8'hbe, 8'hef, 8'h12, 8'h34};
    frame(2'h0, 1'b1, 15);
    slow <= 1'b0;
    ex[1] = 8'h5d;
    for (int i = 3; i < 15; i++) ex[i] = 8'h00;
    frame(2'h1, 1'b0, 15);
    foreach (ex[i]) ex[i] = (i == 0) ? 8'hc8 : 8'hd6;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h0c, {24'h0, ex[i]});
      frame(2'h0, 1'b1, 0);
      apb(1'b0, 8'h14, 32'h0);
      chk(q[1], 1'b1);
      apb(1'b1, 8'h14, 32'h2);
    end
    {c_hi, ba, bb, sa, c_lo, st_hi, st_lo} <= {8'h81, 3'b101, 5'h16, 8'h3c, 4'h9};
    {o_hi, trp, cls, o_lo} <= {2'b10, 1'b1, 1'b0, 6'h1b};
    ex = '{8'ha5, 8'h5e, 8'h03, 8'h81, 8'hb5, 8'h3c, 8'h09, 8'h02, 8'h6d, 0, 0, 0, 0, 0, 0};
    slow <= 1'b1;
    frame(2'h2, 1'b0, 9);
    give_verdict();
  end
endmodule
